/* core/sit_target.sv */
// Write buffer and two-wire indexed-block target with its location bank.

// ----------------------------------------------------------------------------
// Write buffer.
// ----------------------------------------------------------------------------
module sit_fifo
    import sit_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_reg [DEPTH];
    logic [WIDTH-1:0] buf_next [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_reg;
    logic [AW:0]      rd_next;
    logic             full;
    logic             empty;

    assign full          = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty         = (wr_reg == rd_reg);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = buf_reg[rd_reg[AW-1:0]];

    always_comb begin
        buf_next = buf_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        if (in_valid_in && !full) begin
            buf_next[wr_reg[AW-1:0]] = in_data_in;
            wr_next                  = wr_reg + 1'b1;
        end
        if (out_ready_in && !empty) begin
            rd_next = rd_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                buf_reg[i] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            buf_reg <= buf_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
        end
    end

    full_write_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (full && !out_ready_in) |=> $stable(wr_reg))
        else $error("Write buffer accepted a word while full.");

endmodule : sit_fifo

// ----------------------------------------------------------------------------
// Target engine.
// ----------------------------------------------------------------------------
module sit_target
    import sit_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       nrst_in,
    input  wire logic       ref_clk_in,
    input  wire logic [6:0] address_strap_pin_in,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            ref_alive_out
);
    localparam int LAW = $clog2(LOC_COUNT);

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    // ------------------------------------------------------------------------
    // Reference clock watch.
    // ------------------------------------------------------------------------
    logic        ref_tog_reg;
    logic        ref_s1_reg;
    logic        ref_s2_reg;
    logic        ref_s3_reg;
    logic [7:0]  loss_cnt_reg;
    logic [7:0]  loss_cnt_next;
    logic        ref_alive_reg;
    logic        ref_alive_next;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_tog_reg <= 1'b0;
        end else begin
            ref_tog_reg <= !ref_tog_reg;
        end
    end

    always_comb begin
        loss_cnt_next  = loss_cnt_reg;
        ref_alive_next = ref_alive_reg;
        if (ref_s2_reg != ref_s3_reg) begin
            loss_cnt_next  = '0;
            ref_alive_next = 1'b1;
        end else if (loss_cnt_reg == 8'(REF_LOSS_CYC - 1)) begin
            ref_alive_next = 1'b0; // see [R16]
        end else begin
            loss_cnt_next = loss_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_s1_reg    <= 1'b0;
            ref_s2_reg    <= 1'b0;
            ref_s3_reg    <= 1'b0;
            loss_cnt_reg  <= '0;
            ref_alive_reg <= 1'b0;
        end else begin
            ref_s1_reg    <= ref_tog_reg;
            ref_s2_reg    <= ref_s1_reg;
            ref_s3_reg    <= ref_s2_reg;
            loss_cnt_reg  <= loss_cnt_next;
            ref_alive_reg <= ref_alive_next;
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers and strap capture.
    // ------------------------------------------------------------------------
    logic       scl_s1_reg;
    logic       scl_s2_reg;
    logic       scl_s3_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;
    logic       sda_s3_reg;
    logic [6:0] strap_s1_reg;
    logic [6:0] strap_s2_reg;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic       strap_done_reg;
    logic       strap_done_next;
    logic [6:0] addr_reg;
    logic [6:0] addr_next;

    always_comb begin
        settle_next     = settle_reg;
        strap_done_next = strap_done_reg;
        addr_next       = addr_reg;
        if (!strap_done_reg) begin
            if (settle_reg == STRAP_SETTLE) begin
                addr_next       = strap_s2_reg; // see [R8]
                strap_done_next = 1'b1;
            end else begin
                settle_next = settle_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scl_s1_reg     <= 1'b1;
            scl_s2_reg     <= 1'b1;
            scl_s3_reg     <= 1'b1;
            sda_s1_reg     <= 1'b1;
            sda_s2_reg     <= 1'b1;
            sda_s3_reg     <= 1'b1;
            strap_s1_reg   <= '0;
            strap_s2_reg   <= '0;
            settle_reg     <= '0;
            strap_done_reg <= 1'b0;
            addr_reg       <= '0;
        end else begin
            scl_s1_reg     <= scl_in;
            scl_s2_reg     <= scl_s1_reg;
            scl_s3_reg     <= scl_s2_reg;
            sda_s1_reg     <= sda_in;
            sda_s2_reg     <= sda_s1_reg;
            sda_s3_reg     <= sda_s2_reg;
            strap_s1_reg   <= address_strap_pin_in;
            strap_s2_reg   <= strap_s1_reg;
            settle_reg     <= settle_next;
            strap_done_reg <= strap_done_next;
            addr_reg       <= addr_next;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic ev_ok;

    assign scl_rise  = scl_s2_reg && !scl_s3_reg;
    assign scl_fall  = !scl_s2_reg && scl_s3_reg;
    assign start_det = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
    assign stop_det  = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
    assign ev_ok     = ref_alive_reg && !start_det && !stop_det;

    // ------------------------------------------------------------------------
    // Location bank, fed through the write buffer.
    // ------------------------------------------------------------------------
    logic [7:0]  mem_reg [LOC_COUNT];
    logic [7:0]  mem_next [LOC_COUNT];
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic        push_reg;
    logic        push_next;
    logic [15:0] push_word_reg;
    logic [15:0] push_word_next;
    logic        rd_reg;
    logic        rd_next;

    sit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (push_reg),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_word_reg),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    assign fifo_out_ready = !rd_reg;

    function automatic logic [7:0] rd_byte(input logic [7:0] loc);
        if (loc == RSVD_LOC) begin
            return RSVD_VALUE; // see [R18]
        end else if (loc < LOC_LIMIT) begin
            return mem_reg[loc[LAW-1:0]];
        end
        return MEM_RESET;
    endfunction : rd_byte

    always_comb begin
        mem_next = mem_reg;
        if (fifo_out_valid && fifo_out_ready && fifo_out_data[15:8] < LOC_LIMIT
            && fifo_out_data[15:8] != RSVD_LOC) begin
            mem_next[fifo_out_data[8+LAW-1:8]] = fifo_out_data[7:0]; // see [R5]
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < LOC_COUNT; i++) begin
                mem_reg[i] <= (i == int'(BYTE_CNT_LOC)) ? BYTE_CNT_RESET : MEM_RESET; // see [R17]
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    // ------------------------------------------------------------------------
    // Bus engine.
    // ------------------------------------------------------------------------
    sit_state_t state_reg;
    sit_state_t state_next;
    sit_phase_t phase_reg;
    sit_phase_t phase_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] bit_reg;
    logic [2:0] bit_next;
    logic       ack_drv_reg;
    logic       ack_drv_next;
    logic       first_reg;
    logic       first_next;
    logic       hack_reg;
    logic       hack_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic [7:0] left_reg;
    logic [7:0] left_next;
    logic       sda_oe_reg;
    logic       sda_oe_next;
    logic       scl_oe_reg;
    logic       scl_oe_next;
    logic [7:0] rx_byte;
    logic       byte_done;

    assign rx_byte   = {shift_reg[6:0], sda_s2_reg};
    assign byte_done = ev_ok && state_reg == ST_RECV && scl_rise && bit_reg == BIT_LAST;

    always_comb begin
        logic [7:0] tx;
        tx             = first_reg ? rd_byte(BYTE_CNT_LOC) : rd_byte(ptr_reg); // see [R11] [R17]
        state_next     = state_reg;
        phase_next     = phase_reg;
        shift_next     = shift_reg;
        bit_next       = bit_reg;
        ack_drv_next   = ack_drv_reg;
        first_next     = first_reg;
        hack_next      = hack_reg;
        rd_next        = rd_reg;
        ptr_next       = ptr_reg;
        left_next      = left_reg;
        push_next      = push_reg && !fifo_in_ready;
        push_word_next = push_word_reg;
        sda_oe_next    = sda_oe_reg;
        scl_oe_next    = scl_oe_reg && push_next;
        if (!ref_alive_reg || stop_det) begin
            state_next  = ST_IDLE; // see [R16]
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
        end else if (start_det) begin
            state_next   = ST_RECV;
            phase_next   = PH_ADDR;
            bit_next     = '0;
            rd_next      = 1'b0;
            ack_drv_next = 1'b0;
            sda_oe_next  = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == BIT_LAST) begin
                            state_next = ST_ACK;
                            unique case (phase_reg)
                                PH_ADDR: begin
                                    if (rx_byte[7:1] == addr_reg) begin
                                        rd_next    = rx_byte[0]; // see [R2]
                                        first_next = 1'b1;
                                    end else begin
                                        state_next = ST_IDLE; // see [R15]
                                    end
                                end
                                PH_INDEX: ptr_next  = rx_byte; // see [R3]
                                PH_COUNT: left_next = rx_byte; // see [R4]
                                PH_DATA: begin
                                    if (left_reg != 8'h00) begin
                                        push_next      = 1'b1; // see [R5] [R6]
                                        push_word_next = {ptr_reg, rx_byte};
                                        ptr_next       = ptr_reg + 8'h01;
                                        left_next      = left_reg - 8'h01;
                                    end else begin
                                        state_next = ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_drv_reg) begin
                            ack_drv_next = 1'b1;
                            sda_oe_next  = 1'b1; // see [R2] [R6]
                            scl_oe_next  = push_next;
                        end else begin
                            ack_drv_next = 1'b0;
                            bit_next     = '0;
                            if (rd_reg) begin
                                state_next  = ST_SEND;
                                shift_next  = tx;
                                sda_oe_next = !tx[7];
                                first_next  = 1'b0;
                            end else begin
                                state_next  = ST_RECV;
                                sda_oe_next = 1'b0;
                                unique case (phase_reg)
                                    PH_ADDR:  phase_next = PH_INDEX;
                                    PH_INDEX: phase_next = PH_COUNT;
                                    PH_COUNT: phase_next = PH_DATA;
                                    PH_DATA:  phase_next = PH_DATA;
                                endcase
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_reg == BIT_LAST) begin
                            sda_oe_next = 1'b0;
                            state_next  = ST_HACK;
                        end else begin
                            shift_next  = {shift_reg[6:0], 1'b0};
                            bit_next    = bit_reg + 3'h1;
                            sda_oe_next = !shift_reg[6];
                        end
                    end
                end
                ST_HACK: begin
                    if (scl_rise) begin
                        hack_next = !sda_s2_reg;
                    end
                    if (scl_fall) begin
                        if (hack_reg) begin
                            state_next  = ST_SEND;
                            bit_next    = '0;
                            shift_next  = tx;
                            sda_oe_next = !tx[7];
                            ptr_next    = ptr_reg + 8'h01; // see [R12]
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg     <= ST_IDLE;
            phase_reg     <= PH_ADDR;
            shift_reg     <= '0;
            bit_reg       <= '0;
            ack_drv_reg   <= 1'b0;
            first_reg     <= 1'b0;
            hack_reg      <= 1'b0;
            rd_reg        <= 1'b0;
            ptr_reg       <= '0;
            left_reg      <= '0;
            push_reg      <= 1'b0;
            push_word_reg <= '0;
            sda_oe_reg    <= 1'b0;
            scl_oe_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            phase_reg     <= phase_next;
            shift_reg     <= shift_next;
            bit_reg       <= bit_next;
            ack_drv_reg   <= ack_drv_next;
            first_reg     <= first_next;
            hack_reg      <= hack_next;
            rd_reg        <= rd_next;
            ptr_reg       <= ptr_next;
            left_reg      <= left_next;
            push_reg      <= push_next;
            push_word_reg <= push_word_next;
            sda_oe_reg    <= sda_oe_next;
            scl_oe_reg    <= scl_oe_next;
        end
    end

    assign scl_out       = 1'b0;
    assign sda_out       = 1'b0;
    assign scl_oe_out    = scl_oe_reg;
    assign sda_oe_out    = sda_oe_reg;
    assign ref_alive_out = ref_alive_reg;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    addr_ack_a: assert property ( // see [R2]
        (byte_done && phase_reg == PH_ADDR && rx_byte[7:1] == addr_reg) |=> state_reg == ST_ACK)
        else $error("Own address was not acknowledged.");
    foreign_addr_a: assert property ( // see [R15]
        (state_reg == ST_ACK && phase_reg == PH_ADDR) |-> shift_reg[7:1] == addr_reg)
        else $error("Acknowledge phase entered for a foreign address.");
    index_take_a: assert property ( // see [R3]
        (byte_done && phase_reg == PH_INDEX) |=> state_reg == ST_ACK && ptr_reg == $past(rx_byte))
        else $error("Index byte not taken and acknowledged.");
    count_take_a: assert property ( // see [R4]
        (byte_done && phase_reg == PH_COUNT) |=> state_reg == ST_ACK && left_reg == $past(rx_byte))
        else $error("Count byte not taken and acknowledged.");
    data_push_a: assert property ( // see [R5]
        (byte_done && phase_reg == PH_DATA && left_reg != 8'h00)
        |=> push_reg && push_word_reg == {$past(ptr_reg), $past(rx_byte)} && ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("Write byte not queued at the next ascending location.");
    data_ack_a: assert property ( // see [R6]
        (ev_ok && state_reg == ST_ACK && !ack_drv_reg && scl_fall) |=> sda_oe_reg [*1] ##1 ack_drv_reg)
        else $error("Received byte was not acknowledged.");
    strap_hold_a: assert property ( // see [R8]
        strap_done_reg |=> $stable(addr_reg) && strap_done_reg)
        else $error("Captured address changed after capture.");
    ref_dead_a: assert property ( // see [R16]
        !ref_alive_reg |=> state_reg == ST_IDLE && !sda_oe_reg)
        else $error("Interface active while reference clock is stopped.");
    count_first_a: assert property ( // see [R11] [R17]
        (ev_ok && state_reg == ST_ACK && ack_drv_reg && rd_reg && first_reg && scl_fall)
        |=> state_reg == ST_SEND && shift_reg == $past(mem_reg[BYTE_CNT_LOC[LAW-1:0]]))
        else $error("Block read did not start with the count location.");
    rd_ptr_a: assert property ( // see [R12]
        (ev_ok && state_reg == ST_HACK && hack_reg && scl_fall) |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("Read location did not advance.");
    rsvd_ones_a: assert property ( // see [R18]
        (ev_ok && state_reg == ST_HACK && hack_reg && scl_fall && ptr_reg == RSVD_LOC)
        |=> shift_reg == RSVD_VALUE)
        else $error("Reserved location did not read as all ones.");

endmodule : sit_target

/* core/sit_pkg.sv */
// Constants and types shared by the indexed-block management target.
// Contract
// [R1] Host opens block write with start, write address.
// [R2] Device acknowledges its own address.
// [R3] Host sends start index; device acknowledges it.
// [R4] Host sends write count; device acknowledges it.
// [R5] Write bytes stored at ascending locations from index.
// [R6] Device acknowledges each written byte individually. Code does not acknowledge bytes sent after the write count is used up.
// [R7] Host ends block write with stop.
// [R8] Address taken once from strap, then held.
// [R9] Block read: repeated start after index, no stop.
// [R10] Host resends address with read direction.
// [R11] First read byte returned is the count.
// [R12] Then locations from index in ascending order.
// [R13] Host acknowledges count and each data byte.
// [R14] Host ends read with not-acknowledge, then stop.
// [R15] Foreign addresses: no acknowledge, data left undriven.
// [R16] Interface silent while reference clock is stopped.
// [R17] Count comes from writable location, default eight.
// [R18] Reserved location four always reads all ones.
package sit_pkg;

    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         REF_LOSS_NS    = 200;
    localparam int         REF_LOSS_CYC   = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int         LOC_COUNT      = 8;
    localparam int         FIFO_DEPTH     = 4;
    localparam int         FIFO_WIDTH     = 16;
    localparam logic [7:0] LOC_LIMIT      = 8'h08;
    localparam logic [7:0] BYTE_CNT_LOC   = 8'h07;
    localparam logic [7:0] BYTE_CNT_RESET = 8'h08;
    localparam logic [7:0] RSVD_LOC       = 8'h04;
    localparam logic [7:0] RSVD_VALUE     = 8'hFF;
    localparam logic [7:0] MEM_RESET      = 8'h00;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [1:0] STRAP_SETTLE   = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK  = 5'h04,
        ST_SEND = 5'h08,
        ST_HACK = 5'h10
    } sit_state_t;

    typedef enum logic [3:0] {
        PH_ADDR  = 4'h1,
        PH_INDEX = 4'h2,
        PH_COUNT = 4'h4,
        PH_DATA  = 4'h8
    } sit_phase_t;

endpackage : sit_pkg

/* tb/sit_host.sv */
// Behavioural two-wire host that drives the bus clock and data.
module sit_host (
    input  wire logic mclk_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_low_out,
    output logic      sda_low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bus cycles.
    // ------------------------------------------------------------
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    task automatic wait_q();
        repeat (25) @(posedge mclk_in);
    endtask : wait_q
    task automatic bit_io(input logic b, output logic r);
        int n;
        sda_low_out <= !b;
        wait_q();
        scl_low_out <= 1'b0;
        for (n = 0; n < 4000 && scl_in !== 1'b1; n++) begin
            @(posedge mclk_in);
        end
        if (n == 4000) begin
            test_smbus_index_block_target.err_total++;
            test_smbus_index_block_target.print_verdict();
        end
        wait_q();
        r = sda_in;
        wait_q();
        scl_low_out <= 1'b1;
        wait_q();
    endtask : bit_io
    task automatic start_cond();
        sda_low_out <= 1'b0;
        wait_q();
        scl_low_out <= 1'b0;
        wait_q();
        sda_low_out <= 1'b1;
        wait_q();
        scl_low_out <= 1'b1;
        wait_q();
    endtask : start_cond
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        wait_q();
        scl_low_out <= 1'b0;
        wait_q();
        sda_low_out <= 1'b0;
        wait_q();
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : send_byte
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(!ack, r);
    endtask : recv_byte
endmodule : sit_host

/* tb/test_smbus_index_block_target.sv */
// Self-checking bench for the indexed-block management target.
module test_smbus_index_block_target;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bench.
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR = 7'h5A;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       ref_clk = 1'b0;
    logic       ref_run = 1'b1;
    logic [6:0] strap = ADDR;
    logic       h_scl;
    logic       h_sda;
    logic       scl_oe;
    logic       sda_oe;
    logic       ref_alive;
    wire        scl_line = !(h_scl | scl_oe);
    wire        sda_line = !(h_sda | sda_oe);
    int         err_total = 0;
    int         num_checks = 0;
    initial forever #2.5 mclk = ~mclk;
    initial begin
        #7;
        forever #24 if (ref_run) ref_clk = ~ref_clk;
    end
    sit_target i_sit_target (.mclk_in(mclk), .nrst_in(nrst), .ref_clk_in(ref_clk),
        .address_strap_pin_in(strap), .scl_in(scl_line), .scl_out(), .scl_oe_out(scl_oe),
        .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe), .ref_alive_out(ref_alive));
    sit_host i_host (.mclk_in(mclk), .scl_in(scl_line), .sda_in(sda_line),
        .scl_low_out(h_scl), .sda_low_out(h_sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask : check
    task automatic wr(input logic [7:0] b, input logic exp);
        logic a;
        i_host.send_byte(b, a);
        check({7'h00, a}, {7'h00, exp});
    endtask : wr
    task automatic block_write();
        i_host.start_cond();
        wr({ADDR, 1'b0}, 1'b1);
        wr(8'h02, 1'b1);
        wr(8'h03, 1'b1);
        wr(8'hA1, 1'b1);
        wr(8'hB2, 1'b1);
        wr(8'hC3, 1'b1);
        wr(8'h5E, 1'b0);
        i_host.stop_cond();
    endtask : block_write
    task automatic block_read();
        logic [7:0] d;
        logic [7:0] e [4] = '{8'hA1, 8'hB2, 8'hFF, 8'h00};
        i_host.start_cond();
        wr({ADDR, 1'b0}, 1'b1);
        wr(8'h02, 1'b1);
        i_host.start_cond();
        wr({ADDR, 1'b1}, 1'b1);
        i_host.recv_byte(1'b1, d);
        check(d, 8'h08);
        for (int i = 0; i < 4; i++) begin
            i_host.recv_byte(i < 3, d);
            check(d, e[i]);
        end
        i_host.stop_cond();
    endtask : block_read
    task automatic count_write();
        logic [7:0] d;
        i_host.start_cond();
        wr({ADDR, 1'b0}, 1'b1);
        wr(8'h07, 1'b1);
        wr(8'h01, 1'b1);
        wr(8'h03, 1'b1);
        i_host.stop_cond();
        i_host.start_cond();
        wr({ADDR, 1'b0}, 1'b1);
        wr(8'h00, 1'b1);
        i_host.start_cond();
        wr({ADDR, 1'b1}, 1'b1);
        i_host.recv_byte(1'b1, d);
        check(d, 8'h03);
        i_host.recv_byte(1'b0, d);
        check(d, 8'h00);
        i_host.stop_cond();
    endtask : count_write
    task automatic addr_probe(input logic [6:0] a, input logic exp);
        i_host.start_cond();
        wr({a, 1'b0}, exp);
        i_host.stop_cond();
    endtask : addr_probe
    task automatic held_address();
        strap <= 7'h11;
        repeat (20) @(posedge mclk);
        addr_probe(7'h11, 1'b0);
        addr_probe(ADDR, 1'b1);
    endtask : held_address
    task automatic ref_loss();
        ref_run <= 1'b0;
        repeat (100) @(posedge mclk);
        check({7'h00, ref_alive}, 8'h00);
        addr_probe(ADDR, 1'b0);
        ref_run <= 1'b1;
        repeat (60) @(posedge mclk);
        check({7'h00, ref_alive}, 8'h01);
        addr_probe(ADDR, 1'b1);
    endtask : ref_loss
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (60) @(posedge mclk);
        block_write();
        block_read();
        count_write();
        held_address();
        ref_loss();
        print_verdict();
    end
endmodule : test_smbus_index_block_target
